// *** hw/dpx_pkg.sv ***
// constants for the shared memory host port
package dpx_pkg;
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    localparam int MEM_DEPTH = 8192;
    localparam int FLAG_NUM = 8;
    localparam logic [12:0] MBOX_OUT_ADDR = 13'h1FFE;
    localparam logic [12:0] MBOX_IN_ADDR = 13'h1FFF;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    typedef enum logic [1:0] {
        DPX_IDLE = 2'b00,
        DPX_READ = 2'b01,
        DPX_WRITE = 2'b10
    } dpx_acc_t;
endpackage

// *** hw/dpx_host_port.sv ***
// external host port of the shared memory with mailboxes and flags
`timescale 1ns/1ns
module dpx_host_port
    import dpx_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic [dpx_pkg::ADDR_W-1:0] host_port_addr_in,
    input wire logic [dpx_pkg::DATA_W-1:0] host_port_data_in,
    output logic [dpx_pkg::DATA_W-1:0] host_port_data_out,
    output logic host_port_data_oe_out,
    input wire logic host_port_select_n_in,
    input wire logic flag_select_n_in,
    input wire logic host_write_strobe_n_in,
    input wire logic host_read_enable_n_in,
    output logic host_attention_n_out,
    output logic contention_flag_n_out,
    input wire logic attn_set_in,
    input wire logic int_en_in,
    input wire logic int_we_in,
    input wire logic [dpx_pkg::ADDR_W-1:0] int_addr_in,
    input wire logic [dpx_pkg::DATA_W-1:0] int_wdata_in,
    output logic [dpx_pkg::DATA_W-1:0] int_rdata_out,
    output logic host_irq_out
);
    import dpx_pkg::*;

    // two-stage synchronisers for host pins (stage1 read only by stage2)
    logic [ADDR_W-1:0] a_s1_ff, a_s2_ff;
    logic [DATA_W-1:0] d_s1_ff, d_s2_ff;
    logic [3:0] c_s1_ff, c_s2_ff;
    logic [3:0] nxt_c_s1;

    // memory, flags and outputs
    logic [DATA_W-1:0] mem [MEM_DEPTH];
    logic [FLAG_NUM-1:0] flags_ff, nxt_flags;
    logic [DATA_W-1:0] hdata_ff, nxt_hdata;
    logic hoe_ff, nxt_hoe;
    logic attn_n_ff, nxt_attn_n;
    logic busy_n_ff, nxt_busy_n;
    logic irq_ff, nxt_irq;
    dpx_acc_t acc_ff, nxt_acc;
    logic [DATA_W-1:0] irdata_ff;

    // decoded strobes (sync order: cs, ss, wr, rd)
    logic cs, ss, wr, rd, hit, start;

    // pin capture
    always_comb begin
        nxt_c_s1 = {~host_port_select_n_in, ~flag_select_n_in,
                    ~host_write_strobe_n_in, ~host_read_enable_n_in};
    end

    // synchroniser registers, strobes reset inactive
    // address, data capture
    always_ff @(posedge ref_clk_in) begin
        a_s1_ff <= host_port_addr_in;
        a_s2_ff <= a_s1_ff;
        d_s1_ff <= host_port_data_in;
        d_s2_ff <= d_s1_ff;
        if (!rstn_in) begin
            c_s1_ff <= 4'h0;
            c_s2_ff <= 4'h0;
        end else begin
            c_s1_ff <= nxt_c_s1;
            c_s2_ff <= c_s1_ff;
        end
    end

    // access decode and next state
    always_comb begin
        cs = c_s2_ff[3];
        ss = c_s2_ff[2];
        wr = c_s2_ff[1];
        rd = c_s2_ff[0];
        hit = int_en_in && (int_addr_in == a_s2_ff);
        nxt_acc = acc_ff;
        nxt_hdata = hdata_ff;
        nxt_hoe = 1'b0;
        nxt_flags = flags_ff;
        nxt_attn_n = attn_n_ff;
        nxt_irq = irq_ff;
        nxt_busy_n = 1'b1;
        start = 1'b0;
        // default branch returns to idle
        case (acc_ff)
            DPX_IDLE: begin
                if (cs && (wr || rd) && hit) begin
                    nxt_busy_n = 1'b0;
                end else if (cs && wr) begin
                    nxt_acc = DPX_WRITE;
                    start = 1'b1;
                end else if (cs && rd) begin
                    nxt_acc = DPX_READ;
                    start = 1'b1;
                    nxt_hdata = mem[a_s2_ff];
                end else if (ss && wr) begin
                    // write releases or takes flag bit
                    nxt_flags[a_s2_ff[2:0]] = d_s2_ff[0];
                    nxt_acc = DPX_WRITE;
                end else if (ss && rd) begin
                    nxt_hdata = {7'h00, flags_ff[a_s2_ff[2:0]]};
                    nxt_acc = DPX_READ;
                end
            end
            DPX_READ: begin
                nxt_hoe = (cs || ss) && rd;
                if (!nxt_hoe) begin
                    nxt_acc = DPX_IDLE;
                end
            end
            DPX_WRITE: begin
                if (!((cs || ss) && wr)) begin
                    nxt_acc = DPX_IDLE;
                end
            end
            default: nxt_acc = DPX_IDLE;
        endcase
        if (start && rd && a_s2_ff == MBOX_OUT_ADDR) begin
            nxt_attn_n = 1'b1;
        end
        if (attn_set_in) begin
            nxt_attn_n = 1'b0;
        end
        if (int_en_in && !int_we_in && int_addr_in == MBOX_IN_ADDR) begin
            nxt_irq = 1'b0;
        end
        if (start && wr && a_s2_ff == MBOX_IN_ADDR) begin
            nxt_irq = 1'b1;
        end
    end

    // state registers
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            acc_ff <= DPX_IDLE;
            hdata_ff <= DATA_RST;
            hoe_ff <= 1'b0;
            flags_ff <= FLAGS_RST;
            attn_n_ff <= 1'b1;
            busy_n_ff <= 1'b1;
            irq_ff <= 1'b0;
        end else begin
            acc_ff <= nxt_acc;
            hdata_ff <= nxt_hdata;
            hoe_ff <= nxt_hoe;
            flags_ff <= nxt_flags;
            attn_n_ff <= nxt_attn_n;
            busy_n_ff <= nxt_busy_n;
            irq_ff <= nxt_irq;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (int_en_in && int_we_in) begin
            mem[int_addr_in] <= int_wdata_in;
        end else if (start && wr) begin
            mem[a_s2_ff] <= d_s2_ff;
        end
        if (!rstn_in) begin
            irdata_ff <= DATA_RST;
        end else if (int_en_in) begin
            irdata_ff <= mem[int_addr_in];
        end
    end

    // outputs straight from flip-flops
    assign host_port_data_out = hdata_ff;
    assign host_port_data_oe_out = hoe_ff;
    assign host_attention_n_out = attn_n_ff;
    assign contention_flag_n_out = busy_n_ff;
    assign host_irq_out = irq_ff;
    assign int_rdata_out = irdata_ff;

    // checks
    AST_ATTN_SET: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        attn_set_in |=> !host_attention_n_out)
        else $error("attention not raised");
    AST_ATTN_CLR: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        start && rd && a_s2_ff == MBOX_OUT_ADDR && !attn_set_in |=> host_attention_n_out)
        else $error("attention not cleared");
    AST_IRQ_SET: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        start && wr && a_s2_ff == MBOX_IN_ADDR |=> host_irq_out)
        else $error("irq not raised");
    AST_IRQ_CLR: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        int_en_in && !int_we_in && int_addr_in == MBOX_IN_ADDR
        && !(start && wr && a_s2_ff == MBOX_IN_ADDR) |=> !host_irq_out)
        else $error("irq not cleared");
    AST_BUSY: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        acc_ff == DPX_IDLE && cs && (wr || rd) && hit |=> !contention_flag_n_out)
        else $error("busy not flagged");
    AST_NO_START_BUSY: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        !contention_flag_n_out |-> $past(acc_ff) == DPX_IDLE && acc_ff == DPX_IDLE)
        else $error("access started during busy");
    AST_READ_OE: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        acc_ff == DPX_READ && (cs || ss) && rd |=> host_port_data_oe_out)
        else $error("read data not driven");
    AST_OE_ONLY_READ: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        host_port_data_oe_out |-> $past(acc_ff) == DPX_READ)
        else $error("data driven outside read");
    AST_FLAG_WR: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        acc_ff == DPX_IDLE && !cs && ss && wr
        |=> flags_ff[$past(a_s2_ff[2:0])] == $past(d_s2_ff[0]))
        else $error("flag not written");
    AST_MEM_WR: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        start && wr && !(int_en_in && int_we_in)
        |=> mem[$past(a_s2_ff)] == $past(d_s2_ff))
        else $error("memory not written");
    COV_WRITE: cover property (@(posedge ref_clk_in) start && wr);
    COV_READ: cover property (@(posedge ref_clk_in) start && rd);
    COV_BUSY: cover property (@(posedge ref_clk_in) !contention_flag_n_out);
    COV_IRQ: cover property (@(posedge ref_clk_in) $rose(host_irq_out));
endmodule

// *** tb/dpx_host_model.sv ***
// host-side bus model for the shared memory port
`timescale 1ns/1ns
module dpx_host_model
    import dpx_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic [dpx_pkg::DATA_W-1:0] dev_data_in,
    input wire logic dev_oe_in,
    input wire logic busy_n_in,
    output logic [dpx_pkg::ADDR_W-1:0] addr_out,
    output logic [dpx_pkg::DATA_W-1:0] pin_data_out,
    output logic sel_n_out,
    output logic flag_sel_n_out,
    output logic wr_n_out,
    output logic rd_n_out
);
    logic [DATA_W-1:0] drv_ff = 8'h00; // host write data
    logic drv_en = 1'b0; // host drives the data pins
    logic [DATA_W-1:0] last_ff = 8'h00; // last pin level
    int errs = 0; // waits that ran out
    // pin level: device, host, else a floating pattern
    assign pin_data_out = dev_oe_in ? dev_data_in : (drv_en ? drv_ff : ~last_ff);
    always @(posedge ref_clk_in) last_ff <= pin_data_out;
    initial begin
        addr_out = 13'h0000;
        {sel_n_out, flag_sel_n_out, wr_n_out, rd_n_out} = 4'hF;
    end
    // one access, entered at a rising edge; fl picks the flag space
    task automatic access(input logic fl, input logic wr, input logic [12:0] a,
        input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        addr_out <= a;
        drv_ff <= d;
        drv_en <= wr;
        sel_n_out <= fl;
        flag_sel_n_out <= !fl;
        wr_n_out <= !wr;
        rd_n_out <= wr;
        repeat (6) @(posedge ref_clk_in);
        // stretch while busy or data not yet driven
        while ((busy_n_in !== 1'b1 || (!wr && dev_oe_in !== 1'b1)) && n < 40) begin
            @(posedge ref_clk_in);
            n++;
        end
        if (n >= 40) errs++;
        q = pin_data_out;
        {sel_n_out, flag_sel_n_out, wr_n_out, rd_n_out} <= 4'hF;
        drv_en <= 1'b0;
        repeat (5) @(posedge ref_clk_in);
    endtask
endmodule

// *** tb/testbench.sv ***
// self-checking bench for the shared memory host port
`timescale 1ns/1ns
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module testbench;
    import dpx_pkg::*;
    logic ref_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic attn_set_in = 1'b0;
    logic int_en_in = 1'b0;
    logic int_we_in = 1'b0;
    logic [ADDR_W-1:0] int_addr_in = 13'h0000;
    logic [DATA_W-1:0] int_wdata_in = 8'h00;
    logic [DATA_W-1:0] int_rdata_out, dout, pin, q, qi;
    logic [ADDR_W-1:0] addr;
    logic oe, cs_n, fs_n, wr_n, rd_n, attn_n, busy_n, irq;
    logic busy_seen = 1'b0; // busy observed low
    int mismatches = 0;
    int checked = 0;
    initial forever #20 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) if (busy_n === 1'b0) busy_seen <= 1'b1;
    // a host wait that ran out ends the run through the report
    always @(posedge ref_clk_in) if (host.errs != 0) conclude();
    dpx_host_port DUT (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
        .host_port_addr_in(addr), .host_port_data_in(pin), .host_port_data_out(dout),
        .host_port_data_oe_out(oe), .host_port_select_n_in(cs_n),
        .flag_select_n_in(fs_n), .host_write_strobe_n_in(wr_n),
        .host_read_enable_n_in(rd_n), .host_attention_n_out(attn_n),
        .contention_flag_n_out(busy_n), .attn_set_in(attn_set_in), .int_en_in(int_en_in),
        .int_we_in(int_we_in), .int_addr_in(int_addr_in), .int_wdata_in(int_wdata_in),
        .int_rdata_out(int_rdata_out), .host_irq_out(irq));
    dpx_host_model host (.ref_clk_in(ref_clk_in), .dev_data_in(dout), .dev_oe_in(oe),
        .busy_n_in(busy_n), .addr_out(addr), .pin_data_out(pin), .sel_n_out(cs_n),
        .flag_sel_n_out(fs_n), .wr_n_out(wr_n), .rd_n_out(rd_n));
    // one internal access; read data captured into qi
    task automatic int_acc(input logic we, input logic [12:0] a, input logic [7:0] d);
        {int_en_in, int_we_in, int_addr_in, int_wdata_in} <= {1'b1, we, a, d};
        @(posedge ref_clk_in);
        {int_en_in, int_we_in} <= 2'b00;
        @(negedge ref_clk_in);
        qi = int_rdata_out;
        repeat (2) @(posedge ref_clk_in);
    endtask
    task automatic t_mem;
        int_acc(1'b1, 13'h00AA, 8'h5A);
        host.access(1'b0, 1'b0, 13'h00AA, 8'h00, q);
        `CHK(q, 8'h5A)
        host.access(1'b0, 1'b1, 13'h1FFD, 8'hC3, q);
        int_acc(1'b0, 13'h1FFD, 8'h00);
        `CHK(qi, 8'hC3)
        `CHK(irq, 1'b0)
        host.access(1'b0, 1'b1, 13'h1000, 8'h81, q);
        host.access(1'b0, 1'b0, 13'h1000, 8'h00, q);
        `CHK(q, 8'h81)
        int_acc(1'b0, 13'h1000, 8'h00);
        `CHK(qi, 8'h81)
    endtask
    task automatic t_inbox;
        host.access(1'b0, 1'b1, MBOX_IN_ADDR, 8'h00, q);
        `CHK(irq, 1'b1)
        int_acc(1'b0, MBOX_IN_ADDR, 8'h00);
        `CHK(qi, 8'h00)
        `CHK(irq, 1'b0)
    endtask
    task automatic t_attn;
        attn_set_in <= 1'b1;
        @(posedge ref_clk_in);
        attn_set_in <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
        `CHK(attn_n, 1'b0)
        host.access(1'b0, 1'b0, 13'h1FFD, 8'h00, q);
        `CHK(attn_n, 1'b0)
        host.access(1'b0, 1'b0, MBOX_OUT_ADDR, 8'h00, q);
        `CHK(attn_n, 1'b1)
    endtask
    task automatic t_flags;
        for (int i = 0; i < FLAG_NUM; i++) host.access(1'b1, 1'b1, 13'(i), 8'(i % 2), q);
        for (int i = 0; i < FLAG_NUM; i++) begin
            host.access(1'b1, 1'b0, 13'(i), 8'h00, q);
            `CHK(q, 8'(i % 2))
        end
    endtask
    task automatic t_collide;
        int_acc(1'b1, 13'h0055, 8'h77);
        busy_seen <= 1'b0;
        fork
            host.access(1'b0, 1'b0, 13'h0055, 8'h00, q);
            begin
                repeat (6) begin
                    {int_en_in, int_we_in, int_addr_in} <= {2'b10, 13'h0055};
                    @(posedge ref_clk_in);
                end
                // internal side lets go so the stretched host access completes
                int_en_in <= 1'b0;
            end
        join
        int_en_in <= 1'b0;
        `CHK(busy_seen, 1'b1)
        `CHK(q, 8'h77)
    endtask
    task automatic conclude;
        mismatches += host.errs;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge ref_clk_in);
        `CHK({attn_n, busy_n, irq, oe}, 4'hC)
        rstn_in <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
        t_mem();
        t_inbox();
        t_attn();
        t_flags();
        t_collide();
        conclude();
    end
endmodule
